/* duc_top.v */
// Shared control of a two-channel UART: register sets, alternate functions,
// concurrent writes, reset states of pins. Assumes the host bus strobes and
// all engine signals are synchronous to core_clk; iow_n is high between writes.
`timescale 1ns/1ps
`default_nettype none
`include "duc_consts.vh"

module duc_top (
    // Clock and reset
    input  wire       core_clk,
    input  wire       srst,
    // Host register bus
    input  wire       cs_n,
    input  wire       ior_n,
    input  wire       iow_n,
    input  wire       chan_sel,
    input  wire [2:0] addr,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output wire       data_oe,
    // Serial engine, channel A
    input  wire [7:0] rx_hold_a,
    input  wire [7:0] isr_a,
    input  wire [7:0] lsr_a,
    input  wire [7:0] msr_a,
    input  wire       serial_tx_a,
    input  wire       irq_a,
    input  wire       tx_ready_a,
    input  wire       baud_clock_output_a,
    input  wire       receive_ready_flag_a,
    // Serial engine, channel B
    input  wire [7:0] rx_hold_b,
    input  wire [7:0] isr_b,
    input  wire [7:0] lsr_b,
    input  wire [7:0] msr_b,
    input  wire       serial_tx_b,
    input  wire       irq_b,
    input  wire       tx_ready_b,
    input  wire       baud_clock_output_b,
    input  wire       receive_ready_flag_b,
    // Control toward the serial engines
    output wire [7:0] interrupt_enable_reg_a,
    output wire [7:0] line_control_reg_a,
    output wire [7:0] fifo_control_reg_a,
    output wire [7:0] interrupt_enable_reg_b,
    output wire [7:0] line_control_reg_b,
    output wire [7:0] fifo_control_reg_b,
    // Pins, channel A
    output reg        serial_out_chan_a,
    output reg        user_output_two_a_n,
    output reg        rts_a_n,
    output reg        dtr_a_n,
    output reg        irq_out_chan_a,
    output reg        transmit_ready_flag_a_n,
    output wire       multi_function_output_chan_a,
    // Pins, channel B
    output reg        serial_out_chan_b,
    output reg        user_output_two_b_n,
    output reg        rts_b_n,
    output reg        dtr_b_n,
    output reg        irq_out_chan_b,
    output reg        transmit_ready_flag_b_n,
    output wire       multi_function_output_chan_b
);

    // ======================================================================
    // Host strobe decode.
    reg        iow_prev_reg;
    reg  [7:0] alternate_function_control_reg;
    wire       wr_strobe;
    wire       rd_active;
    wire [1:0] chan_wr;
    wire [1:0] chan_dlab;
    wire [7:0] chan_rdata [0:1];
    wire [7:0] chan_mcr   [0:1];
    wire [7:0] chan_ier   [0:1];
    wire [7:0] chan_lcr   [0:1];
    wire [7:0] chan_fcr   [0:1];
    wire [7:0] sel_rdata;
    wire       afr_hit;

    // Remembers the write strobe so a write is taken once, on its falling edge.
    always @(posedge core_clk) begin
        if (srst) begin
            iow_prev_reg <= 1'b1;
        end else begin
            iow_prev_reg <= iow_n;
        end
    end

    assign wr_strobe = !cs_n && !iow_n && iow_prev_reg;
    assign rd_active = !cs_n && !ior_n;
    assign data_oe   = rd_active;

    // Write steering: the selected channel, or both when concurrent mode is on.
    assign chan_wr[0] = wr_strobe && (!chan_sel || alternate_function_control_reg[`DUC_AFR_CONC]);
    assign chan_wr[1] = wr_strobe && (chan_sel || alternate_function_control_reg[`DUC_AFR_CONC]);

    // The shared register sits at the status offset with divisor access set.
    assign afr_hit = (addr == `DUC_ADDR_ISR) && chan_dlab[chan_sel];

    // ======================================================================
    // Alternate-function register, one copy shared by both channels.
    always @(posedge core_clk) begin
        if (srst) begin
            alternate_function_control_reg <= `DUC_RST_AFR;
        end else if (wr_strobe && afr_hit) begin
            alternate_function_control_reg <= {5'h00, data_in[2:0]};
        end
    end

    // ======================================================================
    // Per-channel register sets.
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            duc_chan_regs u_regs (
                .core_clk             (core_clk),
                .srst                 (srst),
                .wr_en                (chan_wr[ch]),
                .addr                 (addr),
                .wdata                (data_in),
                .rdata                (chan_rdata[ch]),
                .rx_hold_in           (ch == 0 ? rx_hold_a : rx_hold_b),
                .isr_in               (ch == 0 ? isr_a : isr_b),
                .lsr_in               (ch == 0 ? lsr_a : lsr_b),
                .msr_in               (ch == 0 ? msr_a : msr_b),
                .interrupt_enable_reg (chan_ier[ch]),
                .line_control_reg     (chan_lcr[ch]),
                .modem_control_reg    (chan_mcr[ch]),
                .fifo_control_reg     (chan_fcr[ch]),
                .dlab                 (chan_dlab[ch])
            );
        end
    endgenerate

    // Control bytes leave through plain arrays, not references into the loop.
    assign interrupt_enable_reg_a = chan_ier[0];
    assign line_control_reg_a     = chan_lcr[0];
    assign fifo_control_reg_a     = chan_fcr[0];
    assign interrupt_enable_reg_b = chan_ier[1];
    assign line_control_reg_b     = chan_lcr[1];
    assign fifo_control_reg_b     = chan_fcr[1];

    // ======================================================================
    // Read path: the shared register on a hit, otherwise the channel picked by channel select.
    assign sel_rdata = afr_hit ? alternate_function_control_reg : chan_rdata[chan_sel];

    // Registers read data every cycle so the bus sees a flop output.
    always @(posedge core_clk) begin
        if (srst) begin
            data_out <= 8'h00;
        end else begin
            data_out <= sel_rdata;
        end
    end

    // ======================================================================
    // Output pins; modem pins follow the inverted control bits.
    always @(posedge core_clk) begin
        if (srst) begin
            serial_out_chan_a       <= 1'b1;
            serial_out_chan_b       <= 1'b1;
            user_output_two_a_n     <= 1'b1;
            user_output_two_b_n     <= 1'b1;
            rts_a_n                 <= 1'b1;
            rts_b_n                 <= 1'b1;
            dtr_a_n                 <= 1'b1;
            dtr_b_n                 <= 1'b1;
            irq_out_chan_a          <= 1'b0;
            irq_out_chan_b          <= 1'b0;
            transmit_ready_flag_a_n <= 1'b0;
            transmit_ready_flag_b_n <= 1'b0;
        end else begin
            serial_out_chan_a       <= serial_tx_a;
            serial_out_chan_b       <= serial_tx_b;
            user_output_two_a_n     <= !chan_mcr[0][`DUC_MCR_OP2];
            user_output_two_b_n     <= !chan_mcr[1][`DUC_MCR_OP2];
            rts_a_n                 <= !chan_mcr[0][`DUC_MCR_RTS];
            rts_b_n                 <= !chan_mcr[1][`DUC_MCR_RTS];
            dtr_a_n                 <= !chan_mcr[0][`DUC_MCR_DTR];
            dtr_b_n                 <= !chan_mcr[1][`DUC_MCR_DTR];
            irq_out_chan_a          <= irq_a;
            irq_out_chan_b          <= irq_b;
            transmit_ready_flag_a_n <= !tx_ready_a;
            transmit_ready_flag_b_n <= !tx_ready_b;
        end
    end

    // ======================================================================
    // Multi-function pins, both steered by the shared select field.
    duc_mf_mux u_mf_a (
        .core_clk        (core_clk),
        .srst            (srst),
        .sel             (alternate_function_control_reg[`DUC_AFR_SEL_HI:`DUC_AFR_SEL_LO]),
        .op2_pin_n       (user_output_two_a_n),
        .baud_clock      (baud_clock_output_a),
        .receive_ready_n (!receive_ready_flag_a),
        .mf_pin_n        (multi_function_output_chan_a)
    );

    duc_mf_mux u_mf_b (
        .core_clk        (core_clk),
        .srst            (srst),
        .sel             (alternate_function_control_reg[`DUC_AFR_SEL_HI:`DUC_AFR_SEL_LO]),
        .op2_pin_n       (user_output_two_b_n),
        .baud_clock      (baud_clock_output_b),
        .receive_ready_n (!receive_ready_flag_b),
        .mf_pin_n        (multi_function_output_chan_b)
    );

endmodule
`default_nettype wire

/* duc_consts.vh */
// Constants for the dual UART shared control block: offsets, fields, resets.
// Assumes inclusion by bare name from each design file of the block.
`ifndef DUC_CONSTS_VH
`define DUC_CONSTS_VH

// ==========================================================================
// Register offsets on the three-bit address.
`define DUC_ADDR_DATA    3'h0
`define DUC_ADDR_IER     3'h1
`define DUC_ADDR_ISR     3'h2
`define DUC_ADDR_LCR     3'h3
`define DUC_ADDR_MCR     3'h4
`define DUC_ADDR_LSR     3'h5
`define DUC_ADDR_MSR     3'h6
`define DUC_ADDR_SCRATCH 3'h7

// ==========================================================================
// Field positions.
`define DUC_LCR_DLAB     7
`define DUC_MCR_DTR      0
`define DUC_MCR_RTS      1
`define DUC_MCR_OP2      3
`define DUC_AFR_CONC     0
`define DUC_AFR_SEL_HI   2
`define DUC_AFR_SEL_LO   1

// ==========================================================================
// Multi-function output select codes.
`define DUC_MF_OP2       2'h0
`define DUC_MF_BAUD      2'h1
`define DUC_MF_RECEIVE_READY_FLAG     2'h2

// ==========================================================================
// Reset values.
`define DUC_RST_CTRL     8'h00
`define DUC_RST_AFR      8'h00
`define DUC_RST_ISR      8'h01
`define DUC_RST_LSR      8'h60
`define DUC_RST_SCRATCH  8'h00

`endif

/* duc_mf_mux.v */
// Multi-function output selector for one channel.
// Assumes all inputs are synchronous to core_clk and already pin-level.
`timescale 1ns/1ps
`default_nettype none
`include "duc_consts.vh"

module duc_mf_mux (
    // Clock and reset
    input  wire       core_clk,
    input  wire       srst,
    // Selection and sources
    input  wire [1:0] sel,
    input  wire       op2_pin_n,
    input  wire       baud_clock,
    input  wire       receive_ready_n,
    // Pin
    output reg        mf_pin_n
);

    reg mf_next;

    // Picks exactly one source; the reserved code parks the pin high.
    always @* begin
        case (sel)
            `DUC_MF_OP2:   mf_next = op2_pin_n;
            `DUC_MF_BAUD:  mf_next = baud_clock;
            `DUC_MF_RECEIVE_READY_FLAG: mf_next = receive_ready_n;
            default:       mf_next = 1'b1;
        endcase
    end

    // Registers the pin; it rests high while reset holds.
    always @(posedge core_clk) begin
        if (srst) begin
            mf_pin_n <= 1'b1;
        end else begin
            mf_pin_n <= mf_next;
        end
    end

endmodule
`default_nettype wire

/* duc_chan_regs.v */
// One channel's control and status register set with its read mux.
// Assumes the write strobe is one cycle long and status inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "duc_consts.vh"

module duc_chan_regs (
    // Clock and reset
    input  wire       core_clk,
    input  wire       srst,
    // Register access
    input  wire       wr_en,
    input  wire [2:0] addr,
    input  wire [7:0] wdata,
    output reg  [7:0] rdata,
    // Status from the serial engine
    input  wire [7:0] rx_hold_in,
    input  wire [7:0] isr_in,
    input  wire [7:0] lsr_in,
    input  wire [7:0] msr_in,
    // Control for the serial engine and pins
    output reg  [7:0] interrupt_enable_reg,
    output reg  [7:0] line_control_reg,
    output reg  [7:0] modem_control_reg,
    output reg  [7:0] fifo_control_reg,
    output wire       dlab
);

    reg [7:0] scratch_byte_reg;
    reg [7:0] isr_reg;
    reg [7:0] lsr_reg;
    reg [7:0] msr_reg;

    assign dlab = line_control_reg[`DUC_LCR_DLAB];

    // Control register writes; divisor offsets belong to the baud block.
    always @(posedge core_clk) begin
        if (srst) begin
            interrupt_enable_reg <= `DUC_RST_CTRL;
            line_control_reg     <= `DUC_RST_CTRL;
            modem_control_reg    <= `DUC_RST_CTRL;
            fifo_control_reg     <= `DUC_RST_CTRL;
            scratch_byte_reg     <= `DUC_RST_SCRATCH;
        end else if (wr_en) begin
            case (addr)
                `DUC_ADDR_IER: if (!dlab) interrupt_enable_reg <= wdata;
                `DUC_ADDR_ISR: if (!dlab) fifo_control_reg <= wdata;
                `DUC_ADDR_LCR: line_control_reg <= wdata;
                `DUC_ADDR_MCR: modem_control_reg <= wdata;
                `DUC_ADDR_SCRATCH: scratch_byte_reg <= wdata;
                default: ;
            endcase
        end
    end

    // Status copies present the documented values while reset holds.
    always @(posedge core_clk) begin
        if (srst) begin
            isr_reg <= `DUC_RST_ISR;
            lsr_reg <= `DUC_RST_LSR;
            msr_reg <= {msr_in[7:4], 4'h0};
        end else begin
            isr_reg <= isr_in;
            lsr_reg <= lsr_in;
            msr_reg <= msr_in;
        end
    end

    // Read mux; divisor offsets read as zero here, alternate-function reads are handled above this.
    always @* begin
        case (addr)
            `DUC_ADDR_DATA:    rdata = dlab ? 8'h00 : rx_hold_in;
            `DUC_ADDR_IER:     rdata = dlab ? 8'h00 : interrupt_enable_reg;
            `DUC_ADDR_ISR:     rdata = isr_reg;
            `DUC_ADDR_LCR:     rdata = line_control_reg;
            `DUC_ADDR_MCR:     rdata = modem_control_reg;
            `DUC_ADDR_LSR:     rdata = lsr_reg;
            `DUC_ADDR_MSR:     rdata = msr_reg;
            default:           rdata = scratch_byte_reg;
        endcase
    end

endmodule
`default_nettype wire

/* duc_monitor.sv */
// Checker for the dual UART shared control top, watching its ports only.
// Assumes one core_clk domain and a bind onto every duc_top instance.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Checker
module duc_monitor (
    // Clock, reset and host bus
    input wire logic       core_clk,
    input wire logic       srst,
    input wire logic       cs_n,
    input wire logic       ior_n,
    input wire logic       iow_n,
    input wire logic       chan_sel,
    input wire logic [2:0] addr,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    // Engine side
    input wire logic [7:0] lsr_b,
    input wire logic [7:0] msr_b,
    input wire logic       serial_tx_a,
    input wire logic       serial_tx_b,
    input wire logic       irq_a,
    input wire logic       tx_ready_a,
    input wire logic [7:0] line_control_reg_a,
    input wire logic [7:0] line_control_reg_b,
    input wire logic [7:0] interrupt_enable_reg_a,
    // Pins
    input wire logic       serial_out_chan_a,
    input wire logic       serial_out_chan_b,
    input wire logic       user_output_two_a_n,
    input wire logic       rts_a_n,
    input wire logic       dtr_a_n,
    input wire logic       irq_out_chan_a,
    input wire logic       transmit_ready_flag_a_n,
    input wire logic       multi_function_output_chan_a
);
    // All checks sample on the rising core clock.
    default clocking @(posedge core_clk); endclocking

    // Reset levels, pin followers and the read path.
    chk_reset_pins: assert property (
        srst |=> {serial_out_chan_a, serial_out_chan_b, user_output_two_a_n, rts_a_n, dtr_a_n,
                  irq_out_chan_a, transmit_ready_flag_a_n, multi_function_output_chan_a} == 8'hF9)
        else $error("pins not at their reset levels");
    chk_tx_follow: assert property (disable iff (srst)
        !$past(srst) |-> serial_out_chan_a == $past(serial_tx_a) && serial_out_chan_b == $past(serial_tx_b))
        else $error("serial outputs do not follow the engines");
    chk_irq_follow: assert property (disable iff (srst)
        !$past(srst) |-> irq_out_chan_a == $past(irq_a) && transmit_ready_flag_a_n == !$past(tx_ready_a))
        else $error("interrupt or ready pin wrong");
    chk_oe_comb: assert property (
        data_oe == (!cs_n && !ior_n))
        else $error("data enable does not match the read strobe");
    chk_reset_dout: assert property (
        srst |=> data_out == 8'h00)
        else $error("read data not cleared by reset");
    chk_reset_ctrl: assert property (
        srst |=> line_control_reg_a == 8'h00 && line_control_reg_b == 8'h00 && interrupt_enable_reg_a == 8'h00)
        else $error("control registers not cleared by reset");
    chk_ctrl_hold: assert property (disable iff (srst)
        (!$past(srst) && ($past(iow_n) || $past(cs_n) || !$past(iow_n, 2)))
        |-> $stable(line_control_reg_a) && $stable(line_control_reg_b))
        else $error("control register changed without a write");
    chk_read_select: assert property (disable iff (srst)
        (!cs_n && !ior_n && addr == 3'h5 && chan_sel && $stable(lsr_b) && !$past(srst))
        |=> data_out == $past(lsr_b))
        else $error("channel B line status read wrong");
    chk_status_reset: assert property (
        (!srst && $past(srst) && (addr == 3'h2 || addr == 3'h5))
        |=> data_out == (($past(addr) == 3'h2) ? 8'h01 : 8'h60))
        else $error("status reset value not seen after reset");
    chk_msr_reset: assert property (
        (!srst && $past(srst) && addr == 3'h6 && chan_sel)
        |=> data_out == {$past(msr_b[7:4], 2), 4'h0})
        else $error("modem status reset value wrong");
endmodule

bind duc_top duc_monitor i_duc_monitor (.*);
`default_nettype wire

/* duc_host.sv */
// Host CPU model driving the parallel register bus of the dual UART.
// Assumes the device takes a write on the first low cycle of iow_n.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Host
module duc_host (
    // Clock
    input  wire logic       core_clk,
    // Strobes, selects and write data
    output var  logic       cs_n,
    output var  logic       ior_n,
    output var  logic       iow_n,
    output var  logic       chan_sel,
    output var  logic [2:0] addr,
    output var  logic [7:0] data_in,
    // Read data and its result strobe
    input  wire logic [7:0] data_out,
    output var  logic       rvalid,
    output var  logic [7:0] rdata
);
    // The bus idles deselected with both strobes high.
    initial begin
        {cs_n, ior_n, iow_n, chan_sel, addr, data_in, rvalid, rdata} = {3'h7, 21'h000000};
    end

    // Write with one low cycle of iow_n; released data shows its inverse.
    task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        {cs_n, iow_n, chan_sel, addr, data_in} = {2'b00, c, a, d};
        @(posedge core_clk);
        #1;
        {cs_n, iow_n, data_in} = {2'b11, ~d};
    endtask

    // Read, taking the registered data one edge after the select.
    task automatic rd(input logic c, input logic [2:0] a);
        @(posedge core_clk);
        #1;
        {cs_n, ior_n, chan_sel, addr} = {2'b00, c, a};
        @(posedge core_clk);
        #1;
        rdata = data_out;
        {cs_n, ior_n, rvalid} = 3'b111;
        @(posedge core_clk);
        #1;
        rvalid = 1'b0;
    endtask
endmodule
`default_nettype wire

/* test_dual_uart_shared_control.sv */
// Self-checking bench for the dual UART shared control top.
// Assumes duc_host as the bus partner and duc_monitor bound to the top.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bench
module test_dual_uart_shared_control;
    logic       core_clk = 1'b0;
    logic       srst = 1'b1;
    logic [7:0] rx_hold_a, rx_hold_b, isr_a, isr_b, lsr_a, lsr_b, msr_a, msr_b, data_in, data_out, rdata, v;
    logic [7:0] interrupt_enable_reg_a, line_control_reg_a, fifo_control_reg_a;
    logic [7:0] interrupt_enable_reg_b, line_control_reg_b, fifo_control_reg_b;
    logic       serial_tx_a, serial_tx_b, irq_a, irq_b, tx_ready_a, tx_ready_b, cs_n, ior_n, iow_n;
    logic       baud_clock_output_a, baud_clock_output_b, receive_ready_flag_a, receive_ready_flag_b;
    logic       chan_sel, data_oe, rvalid, serial_out_chan_a, serial_out_chan_b, irq_out_chan_a, irq_out_chan_b;
    logic       user_output_two_a_n, rts_a_n, dtr_a_n, transmit_ready_flag_a_n, multi_function_output_chan_a;
    logic       user_output_two_b_n, rts_b_n, dtr_b_n, transmit_ready_flag_b_n, multi_function_output_chan_b;
    logic [2:0] addr, pa;
    wire  [11:0] pin_vec = {serial_out_chan_a, user_output_two_a_n, rts_a_n, dtr_a_n, irq_out_chan_a,
                            transmit_ready_flag_a_n, serial_out_chan_b, user_output_two_b_n, rts_b_n, dtr_b_n,
                            irq_out_chan_b, transmit_ready_flag_b_n};
    logic [7:0] exp_q[$];
    int         seed = 75, num_errors = 0, total_checks = 0;

    // Device and host partner.
    duc_top i_duc_top (.*);
    duc_host i_duc_host (.*);

    // Clock of 40 ns period.
    always #20 core_clk = ~core_clk;

    // Counts a comparison and reports a mismatch.
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Compares each returned read with the oldest noted expectation.
    always @(posedge core_clk) begin
        if (rvalid === 1'b1) begin
            chk("read data", rdata, exp_q.pop_front());
        end
    end

    // Notes the expected byte, then reads.
    task automatic rchk(input logic c, input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_duc_host.rd(c, a);
    endtask

    // Fresh random values on every engine input.
    task automatic stim;
        {rx_hold_a, rx_hold_b, isr_a, isr_b} = $random(seed);
        {lsr_a, lsr_b, msr_a, msr_b} = $random(seed);
        {serial_tx_a, serial_tx_b, irq_a, irq_b, tx_ready_a, tx_ready_b, baud_clock_output_a,
         baud_clock_output_b, receive_ready_flag_a, receive_ready_flag_b} = 10'($random(seed));
    endtask

    // Expected pin for a select code: pin level, baud, inverted ready, parked high.
    function automatic logic mf_exp(input logic [1:0] s, input logic op2_n, input logic b, input logic r);
        return (s == 2'h0) ? op2_n : (s == 2'h1) ? b : (s == 2'h2) ? !r : 1'b1;
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        stim();
        {serial_tx_a, serial_tx_b, irq_a, irq_b, tx_ready_a, tx_ready_b} = 6'h0F;
        repeat (10) @(posedge core_clk);
        #1;
        chk("reset pins", pin_vec, 16'h0F3C);
        srst = 1'b0;
        stim();
        for (int c = 0; c < 2; c++) begin
            rchk(c[0], 3'h1, 8'h00);
            rchk(c[0], 3'h4, 8'h00);
            v = 8'($random(seed));
            i_duc_host.wr(c[0], 3'h7, v);
            rchk(c[0], 3'h7, v);
            i_duc_host.wr(c[0], 3'h2, 8'hC1);
            chk("fcr", {fifo_control_reg_a, fifo_control_reg_b}, c ? 16'hC1C1 : 16'hC100);
            rchk(c[0], 3'h3, 8'h00);
        end
        $display("reset and scratch test done");
        i_duc_host.wr(1'b0, 3'h3, 8'h80);
        i_duc_host.wr(1'b1, 3'h3, 8'h80);
        i_duc_host.wr(1'b0, 3'h2, 8'hFF);
        rchk(1'b0, 3'h2, 8'h07);
        rchk(1'b1, 3'h2, 8'h07);
        i_duc_host.wr(1'b1, 3'h2, 8'h00);
        rchk(1'b0, 3'h2, 8'h00);
        $display("alternate function test done");
        i_duc_host.wr(1'b0, 3'h2, 8'h01);
        i_duc_host.wr(1'b0, 3'h3, 8'h03);
        rchk(1'b1, 3'h3, 8'h03);
        v = 8'($random(seed));
        i_duc_host.wr(1'b1, 3'h7, v);
        rchk(1'b0, 3'h7, v);
        rchk(1'b0, 3'h5, lsr_a);
        rchk(1'b1, 3'h5, lsr_b);
        i_duc_host.wr(1'b1, 3'h3, 8'h80);
        i_duc_host.wr(1'b0, 3'h2, 8'h00);
        i_duc_host.wr(1'b0, 3'h7, ~v);
        rchk(1'b1, 3'h7, v);
        rchk(1'b0, 3'h7, ~v);
        $display("concurrent write test done");
        i_duc_host.wr(1'b0, 3'h4, 8'h08);
        for (int k = 0; k < 8; k++) begin
            i_duc_host.wr(1'b0, 3'h2, {5'h00, k[1:0], 1'b0});
            stim();
            repeat (3) @(posedge core_clk);
            #1;
            chk("mf a", multi_function_output_chan_a,
                mf_exp(k[1:0], 1'b0, baud_clock_output_a, receive_ready_flag_a));
            chk("mf b", multi_function_output_chan_b,
                mf_exp(k[1:0], 1'b1, baud_clock_output_b, receive_ready_flag_b));
        end
        $display("multi-function test done");
        // Mid-run resets, each released with a status offset left on the bus.
        for (int r = 0; r < 3; r++) begin
            pa = (r == 0) ? 3'h5 : (r == 1) ? 3'h6 : 3'h2;
            rchk(r != 2, pa, (r == 0) ? lsr_b : (r == 1) ? msr_b : isr_a);
            srst = 1'b1;
            repeat (3) @(posedge core_clk);
            #1;
            chk("mid reset pins", pin_vec, 16'h0F3C);
            chk("mid reset fcr", {fifo_control_reg_a, fifo_control_reg_b}, 16'h0000);
            srst = 1'b0;
            rchk(1'b0, 3'h4, 8'h00);
        end
        i_duc_host.wr(1'b0, 3'h3, 8'h80);
        rchk(1'b0, 3'h2, 8'h00);
        $display("mid-run reset test done");
        repeat (4) @(posedge core_clk);
        wrap_up();
    end

    // Watchdog: the sequence needs under two hundred cycles, so 2000 means a hang.
    initial begin
        #80000;
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
